// ### logic/spipp_pkg.sv
// package: constants, field positions and carrier types for the spi peripheral port
//
// What this block does
// - port is a peripheral while control bit 0 is clear, driving host-in data only while select is low
// - format bit 16 chooses clock phase: clear is phase 0, set is phase 1
// - format bit 17 is clock polarity and picks which serial edge is active
// - host-in data changes after rising edge when polarity equals phase, else falling
// - host-out data sampled on falling edge when polarity equals phase, else rising
package spipp_pkg;

  // ----------------------------------------------------------------
  // register field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 0;
  localparam int PHASE_BIT     = 16;
  localparam int POLARITY_BIT  = 17;
  localparam int PRESCALE_LSB  = 8;
  localparam int PRESCALE_MSB  = 15;

  // ----------------------------------------------------------------
  // word format and timing
  // ----------------------------------------------------------------
  localparam int          WORD_BITS      = 16;
  localparam logic [4:0]  LAST_BIT_CNT   = 5'h0F;
  localparam logic [4:0]  FULL_BIT_CNT   = 5'h10;
  localparam int          CORE_PERIOD_NS = 40;
  localparam int          SCLK_MIN_NS    = 25;
  localparam int          SCLK_MIN_CYC   = (SCLK_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int          CS_LEAD_SCLKS  = 2;

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ctrlMode;
    logic       clkPol;
    logic       clkPha;
    logic [7:0] prescale;
  } spipp_cfg_type;

endpackage

// ### logic/spipp_port.sv
// module: spi peripheral port, serial side on the host clock, word side on core_clk
`timescale 1ns/10ps
module spipp_port
  import spipp_pkg::*;
#(
  parameter int WIDTH = WORD_BITS
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [31:0]       globalControl,
  input  wire logic [31:0]       formatReg,
  input  wire logic [WIDTH-1:0]  txData,
  input  wire logic              txValid,
  output logic                   txReady,
  output logic [WIDTH-1:0]       rxData,
  output logic                   rxValid,
  input  wire logic              serialClockPin,
  input  wire logic              chipSelectN,
  input  wire logic              hostOutDataPin,
  output logic                   hostInDataPin,
  output logic                   hostInDataOe
);

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  spipp_cfg_type cfg;
  logic          peripheralMode;
  logic          sameSense;
  logic          sampleClk;
  assign cfg.ctrlMode  = globalControl[CTRL_MODE_BIT];
  assign cfg.clkPha    = formatReg[PHASE_BIT];
  assign cfg.clkPol    = formatReg[POLARITY_BIT];
  assign cfg.prescale  = formatReg[PRESCALE_MSB:PRESCALE_LSB];
  assign peripheralMode = ~cfg.ctrlMode;
  assign sameSense      = ~(cfg.clkPol ^ cfg.clkPha);
  // rises on falling serial edge when polarity equals phase, else on rising
  assign sampleClk      = serialClockPin ^ sameSense;

  // ----------------------------------------------------------------
  // link side: sample and launch edges, select high clears the frame
  // ----------------------------------------------------------------
  logic [4:0]       bitCnt_r;
  logic [WIDTH-1:0] rxShift_r;
  logic [WIDTH-1:0] rxShift_nxt;
  logic [WIDTH-1:0] rxWordLink_r;
  logic             rxToggle_r;
  logic [4:0]       launchCnt_r;
  logic [4:0]       bitSel;
  assign rxShift_nxt = {rxShift_r[WIDTH-2:0], hostOutDataPin};

  // shift in msb first, count bits of the frame
  always_ff @(posedge sampleClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      bitCnt_r  <= 5'h00;
      rxShift_r <= '0;
    end else begin
      rxShift_r <= rxShift_nxt;
      if (bitCnt_r != FULL_BIT_CNT)
        bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // hand the full word over and flip the event toggle
  always_ff @(posedge sampleClk or posedge reset) begin
    if (reset) begin
      rxToggle_r <= 1'b0;
    end else if (!chipSelectN && bitCnt_r == LAST_BIT_CNT) begin
      rxToggle_r <= ~rxToggle_r;
    end
  end

  // word holder, stable for at least a full frame after the toggle
  always_ff @(posedge sampleClk) begin
    if (!chipSelectN && bitCnt_r == LAST_BIT_CNT)
      rxWordLink_r <= rxShift_nxt;
  end

  // launch edges are the opposite serial edges
  always_ff @(negedge sampleClk or posedge chipSelectN) begin
    if (chipSelectN)
      launchCnt_r <= 5'h00;
    else if (launchCnt_r != FULL_BIT_CNT)
      launchCnt_r <= launchCnt_r + 5'h01;
  end

  // phase 1 opens with a sample edge, so bit 15 stands before it
  assign bitSel = cfg.clkPha ? launchCnt_r
                : ((launchCnt_r == 5'h00) ? 5'h00 : launchCnt_r - 5'h01);

  // ----------------------------------------------------------------
  // core side: crossings and word ports
  // ----------------------------------------------------------------
  logic [1:0]       csSync_r;
  logic [2:0]       rxTogSync_r;
  logic [WIDTH-1:0] txHold_r;
  logic             txReady_r;
  logic             rxValid_r;
  logic [WIDTH-1:0] rxData_r;
  logic             txTake;
  logic             rxEvent;
  logic [3:0]       txIdx;
  assign txTake  = txValid && txReady_r;
  assign rxEvent = rxTogSync_r[2] != rxTogSync_r[1];

  // two-flop sync of select and of the word toggle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      csSync_r    <= 2'h3;
      rxTogSync_r <= 3'h0;
    end else begin
      csSync_r    <= {csSync_r[0], chipSelectN};
      rxTogSync_r <= {rxTogSync_r[1:0], rxToggle_r};
    end
  end

  // transmit word is accepted only between frames
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txHold_r  <= '0;
      txReady_r <= 1'b0;
    end else begin
      txReady_r <= csSync_r[1];
      if (txTake)
        txHold_r <= txData;
    end
  end

  // receive pulse and word, one cycle after the toggle is seen
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxValid_r <= 1'b0;
      rxData_r  <= '0;
    end else begin
      rxValid_r <= rxEvent;
      if (rxEvent)
        rxData_r <= rxWordLink_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign txIdx         = 4'(WIDTH - 1) - bitSel[3:0];
  assign txReady       = txReady_r;
  assign rxValid       = rxValid_r;
  assign rxData        = rxData_r;
  assign hostInDataPin = txHold_r[txIdx];
  assign hostInDataOe  = peripheralMode && !chipSelectN;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_rx_one_pulse;
    @(posedge core_clk) disable iff (reset) rxValid_r |=> !rxValid_r;
  endproperty
  a_rx_one_pulse: assert property (p_rx_one_pulse) else $error("rx valid longer than one cycle");

  property p_rx_word_taken;
    @(posedge core_clk) disable iff (reset) rxEvent |=> rxValid_r && rxData_r == $past(rxWordLink_r);
  endproperty
  a_rx_word_taken: assert property (p_rx_word_taken) else $error("received word not delivered");

  property p_tx_stable_in_frame;
    @(posedge core_clk) disable iff (reset) !txReady_r |=> $stable(txHold_r);
  endproperty
  a_tx_stable_in_frame: assert property (p_tx_stable_in_frame) else $error("tx word changed in frame");

  property p_ready_follows_cs;
    @(posedge core_clk) disable iff (reset) !$past(reset) |-> txReady_r == $past(csSync_r[1]);
  endproperty
  a_ready_follows_cs: assert property (p_ready_follows_cs) else $error("ready not tied to idle select");

  property p_drive_only_peripheral;
    @(posedge core_clk) disable iff (reset) hostInDataOe |-> !cfg.ctrlMode && !chipSelectN;
  endproperty
  a_drive_only_peripheral: assert property (p_drive_only_peripheral) else $error("drives in controller mode");

  property p_cnt_bounded;
    @(posedge sampleClk) disable iff (chipSelectN) bitCnt_r <= FULL_BIT_CNT;
  endproperty
  a_cnt_bounded: assert property (p_cnt_bounded) else $error("bit count overran");

  // checked on the launch edge that follows the sixteenth sample, inside the frame; only phase 1 frames have one, phase 0 ends on that sample
  property p_rx_capture;
    @(negedge sampleClk) disable iff (chipSelectN)
      bitCnt_r == FULL_BIT_CNT |-> rxWordLink_r == rxShift_r;
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("sixteenth bit not captured");

  property p_msb_first;
    @(negedge sampleClk) disable iff (chipSelectN) launchCnt_r == 5'h00 |-> hostInDataPin == txHold_r[WIDTH-1];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not msb");

  property p_launch_bounded;
    @(negedge sampleClk) disable iff (chipSelectN) launchCnt_r <= FULL_BIT_CNT;
  endproperty
  a_launch_bounded: assert property (p_launch_bounded) else $error("launch count overran");

  property p_rx_hold;
    @(posedge core_clk) disable iff (reset) !rxValid_r |-> $stable(rxData_r);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word changed without valid");

  property p_rx_matches_link;
    @(posedge core_clk) disable iff (reset) rxValid_r |-> rxData_r == rxWordLink_r;
  endproperty
  a_rx_matches_link: assert property (p_rx_matches_link) else $error("rx word differs from link word");

  property p_ready_low_in_frame;
    @(posedge core_clk) disable iff (reset) !csSync_r[1] |=> !txReady_r;
  endproperty
  a_ready_low_in_frame: assert property (p_ready_low_in_frame) else $error("ready high inside frame");

  property p_oe_off_in_ctrl;
    @(posedge core_clk) disable iff (reset) cfg.ctrlMode |-> !hostInDataOe;
  endproperty
  a_oe_off_in_ctrl: assert property (p_oe_off_in_ctrl) else $error("host-in driven in controller mode");

  c_rx_word:   cover property (@(posedge core_clk) disable iff (reset) rxValid_r);
  c_phase_one: cover property (@(posedge core_clk) disable iff (reset) rxValid_r && cfg.clkPha);
  c_tx_taken:  cover property (@(posedge core_clk) disable iff (reset) txTake ##[1:200] rxValid_r);
  c_ctrl_rx:   cover property (@(posedge core_clk) disable iff (reset) rxValid_r && cfg.ctrlMode);
  c_pol_one:   cover property (@(posedge core_clk) disable iff (reset) rxValid_r && cfg.clkPol);

endmodule // spipp_port

// ### tb/spipp_host_model.sv
// host controller model that drives the serial side of the port
`timescale 1ns/10ps
module spipp_host_model (
  output logic      serialClockPin,
  output logic      chipSelectN,
  output logic      hostOutDataPin,
  input  wire logic misoLine,
  input  wire logic hostInDataOe
);
  // 160 ns period: at least (prescale+1)*40 ns for prescale 1..3, above 25 ns
  localparam int HALF_NS = 80;

  // lines idle with select high
  initial begin
    serialClockPin = 1'b0;
    chipSelectN    = 1'b1;
    hostOutDataPin = 1'b0;
  end

  // one select frame of nBits clocks, msb first
  task automatic xfer(input logic pol, input logic pha, input logic [15:0] outWord, input int nBits,
                      output logic [15:0] inWord, output int oeCnt);
    logic [15:0] sh;
    logic        smp;
    sh = outWord;
    inWord = '0;
    oeCnt = 0;
    #(1 + $urandom % 19); // keep link edges off the core_clk rising edge
    serialClockPin = pol; // idle level set by polarity
    #(2*HALF_NS);
    chipSelectN = 1'b0;
    hostOutDataPin = sh[15]; // msb first
    #(4*HALF_NS); // two serial periods before clocking
    for (int i = 0; i < 2*nBits; i++) begin
      smp = ((i % 2) != pha); // sample edge of the port
      if (smp) begin
        inWord = {inWord[14:0], misoLine};
        oeCnt += (hostInDataOe === 1'b1);
      end
      serialClockPin = ~serialClockPin;
      #20;
      if (smp) begin
        sh = sh << 1;
        hostOutDataPin = sh[15];
      end
      #(HALF_NS-20);
    end
    #HALF_NS;
    chipSelectN = 1'b1; // select raised after every word
    hostOutDataPin = ~hostOutDataPin; // released line shows no stale bit
    #(2*HALF_NS);
  endtask
endmodule // spipp_host_model

// ### tb/test_spi_peripheral_port.sv
// self-checking bench for the spi peripheral port
`timescale 1ns/10ps
module test_spi_peripheral_port;
  import spipp_pkg::*;
  logic        core_clk, reset, txValid, txReady, rxValid, misoFloat;
  logic        serialClockPin, chipSelectN, hostOutDataPin, hostInDataPin, hostInDataOe;
  logic [31:0] globalControl, formatReg;
  logic [15:0] txData, rxData;
  wire logic   misoLine;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [15:0] rxExp[$];

  // undriven host-in line toggles every cycle
  assign misoLine = hostInDataOe ? hostInDataPin : misoFloat;

  spipp_port u_dut (.core_clk(core_clk), .reset(reset), .globalControl(globalControl),
    .formatReg(formatReg), .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .serialClockPin(serialClockPin),
    .chipSelectN(chipSelectN), .hostOutDataPin(hostOutDataPin),
    .hostInDataPin(hostInDataPin), .hostInDataOe(hostInDataOe));

  spipp_host_model u_host (.serialClockPin(serialClockPin), .chipSelectN(chipSelectN),
    .hostOutDataPin(hostOutDataPin), .misoLine(misoLine), .hostInDataOe(hostInDataOe));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // received words against the model queue, plus the cycle ceiling
  always @(posedge core_clk) begin
    misoFloat <= ~misoFloat;
    cycles <= cycles + 1;
    if (rxValid === 1'b1) begin
      if (rxExp.size() == 0) check("unexpected rxValid", 0, 1);
      else check("rxData", rxExp.pop_front(), rxData);
    end
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  // offer a random word, then run one frame with a random host word
  task automatic frame(input logic ctrl, input logic pol, input logic pha, input int nBits);
    logic [15:0] tw, hw, got;
    int          oeCnt, n;
    tw = 16'($urandom);
    hw = 16'($urandom);
    n = 0;
    @(posedge core_clk);
    globalControl <= {31'h0, ctrl};
    formatReg <= {14'h0, pol, pha, 8'(1 + $urandom % 3), 8'h00};
    while (txReady !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    check("txReady", 1, txReady);
    txData <= tw;
    txValid <= 1'b1;
    @(posedge core_clk);
    txValid <= 1'b0;
    repeat (4) @(posedge core_clk);
    if (nBits == 16) rxExp.push_back(hw);
    u_host.xfer(pol, pha, hw, nBits, got, oeCnt);
    check("hostInDataOe count", ctrl ? 0 : nBits, oeCnt);
    if (!ctrl && nBits == 16) check("host-in word", tw, got);
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    reset = 1'b1;
    txValid = 1'b0;
    txData = '0;
    globalControl = '0;
    formatReg = '0;
    misoFloat = 1'b0;
    void'($urandom(49971));
    repeat (8) @(posedge core_clk);
    check("rxData after reset", 0, rxData);
    reset <= 1'b0;
    for (int m = 0; m < 8; m++) frame(1'b0, m[1], m[0], 16);
    frame(1'b0, 1'b1, 1'b0, 8);
    frame(1'b1, 1'b0, 1'b1, 16);
    frame(1'b0, 1'b0, 1'b0, 16);
    check("pending rx words", 0, rxExp.size());
    give_verdict();
  end
endmodule // test_spi_peripheral_port
